// ### src/ntim_target.sv
// nand target end: power-on init, orientation decode, status and ddr data output
`timescale 1ns/1ps
`default_nettype none
`include "ntim_defines.svh"

module ntim_target #(
  parameter int unsigned POR_CYC = `NTIM_POR_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic vccq_1v8_i,
  input  wire logic cs_reduce_i,
  ntim_link_if.dev  link,
  output logic      mirrored_o,
  output logic      async_if_o,
  output logic      seq_init_o,
  output logic      par_init_o,
  output logic      lun_sel_o,
  output logic      busy_o
);
  import ntim_pkg::*;

  localparam int DLY = `NTIM_DQSRE_CYC;

  logic [14:0]     s1_q, s2_q;
  logic            we_d_q, re_d_q;
  ntim_dev_state_t st_q;
  logic [15:0]     pwr_cnt_q;
  logic [15:0]     busy_cnt_q;
  logic            first_rst_q, orient_q, mirrored_q, async_q;
  logic            seq_q, par_q, lun_q, unit_wait_q, armed_q;
  ntim_out_mode_t  om_q;
  logic [DLY-1:0]  re_pipe_q;
  logic            dqs_q, dq_oe_q, rb_n_q, busy_q;
  logic [7:0]      dq_o_q, data_ctr_q;
  logic [7:0]      dq_rev, out_byte, out_rev;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // every pin passes two flops; only s2 is read by logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // select and strobes start at their idle high level: no false edge after reset
      s1_q <= 15'h1300;
      s2_q <= 15'h1300;
    end else if (en_i) begin
      s1_q <= {vccq_1v8_i, cs_reduce_i, link.ce_n, link.cle, link.ale,
               link.we_n, link.read_enable_n, link.d_dq_i};
      s2_q <= s1_q;
    end
  end

  wire       strap_s = s2_q[14];
  wire       csr_s   = s2_q[13];
  wire       ce_s    = s2_q[12];
  wire       cle_s   = s2_q[11];
  wire       ale_s   = s2_q[10];
  wire       we_s    = s2_q[9];
  wire       re_s    = s2_q[8];
  wire [7:0] dq_s    = s2_q[7:0];

  // edge history of the synchronised strobes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      we_d_q <= 1'b1;
      re_d_q <= 1'b1;
    end else if (en_i) begin
      we_d_q <= we_s;
      re_d_q <= re_s;
    end
  end

  // data line reversal both ways; control pins never pass through here
  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign dq_rev[i]  = dq_s[7-i];
    assign out_rev[i] = out_byte[7-i];
  end

  wire       busy      = (busy_cnt_q != 16'h0000);
  wire       we_rise   = we_s & ~we_d_q & ~ce_s & (st_q == DS_RUN);
  wire       cmd_stb   = we_rise & cle_s & ~ale_s;
  wire       addr_stb  = we_rise & ale_s & ~cle_s;
  wire [7:0] bus_byte  = mirrored_q ? dq_rev : dq_s;
  wire       first_mir = ~orient_q & (dq_s == `NTIM_CMD_STATUS_MIRR);
  wire [7:0] cmd       = first_mir ? `NTIM_CMD_STATUS : bus_byte;

  // ---------------------------------------------------------------
  // power-up and interface select
  // ---------------------------------------------------------------
  // ready/busy stays low until valid, then the strap is caught once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q      <= DS_PWRUP;
      pwr_cnt_q <= 16'h0000;
      async_q   <= 1'b0;
    end else if (en_i && st_q == DS_PWRUP) begin
      pwr_cnt_q <= pwr_cnt_q + 16'h0001;
      if (pwr_cnt_q == 16'(`NTIM_RBVALID_CYC - 1)) begin
        st_q    <= DS_RUN;
        async_q <= strap_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // orientation
  // ---------------------------------------------------------------
  // decided by the first command that is not the symmetric reset code;
  // only power-down (reset pin) clears it, full reinit leaves it alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      orient_q   <= 1'b0;
      mirrored_q <= 1'b0;
    end else if (en_i && cmd_stb && !orient_q && dq_s != `NTIM_CMD_RESET) begin
      orient_q <= 1'b1;
      if (first_mir) begin
        mirrored_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // busy timing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_q  <= 16'h0000;
      first_rst_q <= 1'b0;
    end else if (en_i) begin
      if (cmd_stb && cmd == `NTIM_CMD_RESET && !first_rst_q) begin
        first_rst_q <= 1'b1;
        busy_cnt_q  <= 16'(POR_CYC);
      end else if (cmd_stb && !busy && (cmd == `NTIM_CMD_RESET ||
                   cmd == `NTIM_CMD_FULL_REINIT)) begin
        busy_cnt_q <= 16'(`NTIM_RST_CYC);
      end else if (cmd_stb && !busy && armed_q && cmd == `NTIM_CMD_READ_GO) begin
        busy_cnt_q <= 16'(`NTIM_READ_CYC);
      end else if (busy) begin
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
    end
  end

  // initialisation style under chip-select reduction, fixed by first status
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_q <= 1'b0;
      par_q <= 1'b0;
    end else if (en_i && cmd_stb && cmd == `NTIM_CMD_STATUS && csr_s &&
                 !seq_q && !par_q) begin
      seq_q <= ~first_rst_q;
      par_q <= first_rst_q;
    end
  end

  // ---------------------------------------------------------------
  // command decode and output mode
  // ---------------------------------------------------------------
  // a busy die drops everything except the two status reads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      om_q        <= OM_NONE;
      lun_q       <= 1'b0;
      unit_wait_q <= 1'b0;
      armed_q     <= 1'b0;
    end else if (en_i) begin
      if (cmd_stb) begin
        case (cmd)
          `NTIM_CMD_STATUS:      om_q <= OM_STATUS;
          `NTIM_CMD_UNIT_STATUS: begin
            om_q        <= OM_STATUS;
            unit_wait_q <= 1'b1;
          end
          `NTIM_CMD_RESET,
          `NTIM_CMD_FULL_REINIT: if (!busy) begin
            om_q    <= OM_NONE;
            lun_q   <= 1'b0;
            armed_q <= 1'b0;
          end
          `NTIM_CMD_READ_SETUP: if (!busy) begin
            om_q    <= OM_NONE;
            armed_q <= 1'b1;
          end
          `NTIM_CMD_READ_GO: if (!busy && armed_q) begin
            om_q    <= OM_DATA;
            armed_q <= 1'b0;
          end
          default: if (!busy) om_q <= OM_NONE;
        endcase
      end else if (addr_stb && unit_wait_q) begin
        lun_q       <= bus_byte[0];  // unit address taken even when busy
        unit_wait_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // ddr output path
  // ---------------------------------------------------------------
  assign out_byte = (om_q == OM_STATUS) ?
                    {1'b1, ~busy, ~busy, 5'b00000} : data_ctr_q;

  // strobe copies read enable a fixed delay later; each strobe edge,
  // up to the final rise and fall, launches one byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      re_pipe_q  <= '1;
      dqs_q      <= 1'b1;
      dq_o_q     <= 8'h00;
      data_ctr_q <= 8'h00;
    end else if (en_i) begin
      re_pipe_q <= {re_pipe_q[DLY-2:0], re_s};
      dqs_q     <= re_pipe_q[DLY-1];
      if (re_pipe_q[DLY-1] != dqs_q && om_q == OM_STATUS) begin
        dq_o_q <= mirrored_q ? out_rev : out_byte;
      end else if (re_pipe_q[DLY-1] != dqs_q && om_q == OM_DATA && !busy) begin
        dq_o_q     <= mirrored_q ? out_rev : out_byte;
        data_ctr_q <= data_ctr_q + 8'h01;
      end
      if (cmd_stb && cmd == `NTIM_CMD_READ_GO) begin
        data_ctr_q <= 8'h00;
      end
    end
  end

  // drive only in output phases and never while host owns the lines
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_oe_q <= 1'b0;
      rb_n_q  <= 1'b0;  // not valid yet: held low
      busy_q  <= 1'b1;
    end else if (en_i) begin
      dq_oe_q <= (om_q != OM_NONE) && !ce_s && !cle_s && !ale_s &&
                 !(om_q == OM_DATA && busy);
      rb_n_q  <= (st_q == DS_RUN) && !busy;
      busy_q  <= (st_q != DS_RUN) || busy;
    end
  end

  assign link.d_dq_o  = dq_o_q;
  assign link.d_dq_oe = dq_oe_q;
  assign link.dqs     = dqs_q;
  assign link.rb_n    = rb_n_q;
  assign mirrored_o   = mirrored_q;
  assign async_if_o   = async_q;
  assign seq_init_o   = seq_q;
  assign par_init_o   = par_q;
  assign lun_sel_o    = lun_q;
  assign busy_o       = busy_q;
endmodule // ntim_target
`default_nettype wire

// ### src/ntim_defines.svh
// constants shared by the target and host ends of the nand link
`ifndef NTIM_DEFINES_SVH
`define NTIM_DEFINES_SVH

`define NTIM_CLK_MHZ          25
// command codes as they appear at the target after orientation, except the mirrored status code, which is as seen before it
`define NTIM_CMD_RESET        8'hff
`define NTIM_CMD_FULL_REINIT  8'hfd
`define NTIM_CMD_STATUS       8'h70
`define NTIM_CMD_STATUS_MIRR  8'h0e
`define NTIM_CMD_UNIT_STATUS  8'h78
`define NTIM_CMD_READ_SETUP   8'h00
`define NTIM_CMD_READ_GO      8'h30
// status byte fields
`define NTIM_ST_WP_N_BIT      7
`define NTIM_ST_RDY_BIT       6
`define NTIM_ST_ARDY_BIT      5
// times in their own units
`define NTIM_RBVALID_US       10
`define NTIM_HOST_WAIT_US     100
`define NTIM_POR_US           1000
`define NTIM_RST_US           5
`define NTIM_READ_US          2
`define NTIM_DQSRE_NS         80
`define NTIM_RPST_NS          400
// derived cycle counts (least times round up)
`define NTIM_RBVALID_CYC      (`NTIM_RBVALID_US * `NTIM_CLK_MHZ)
`define NTIM_HOST_WAIT_CYC    (`NTIM_HOST_WAIT_US * `NTIM_CLK_MHZ)
`define NTIM_POR_CYC          (`NTIM_POR_US * `NTIM_CLK_MHZ)
`define NTIM_RST_CYC          (`NTIM_RST_US * `NTIM_CLK_MHZ)
`define NTIM_READ_CYC         (`NTIM_READ_US * `NTIM_CLK_MHZ)
`define NTIM_DQSRE_CYC        ((`NTIM_DQSRE_NS * `NTIM_CLK_MHZ + 999) / 1000)
`define NTIM_RPST_CYC         ((`NTIM_RPST_NS * `NTIM_CLK_MHZ + 999) / 1000)
// host pacing: half period of the link strobes, settle margins
`define NTIM_HALF_CYC         4
`define NTIM_RB_GUARD_CYC     8
`define NTIM_CAPTURE_LAT_CYC  8

`endif

// ### src/ntim_pkg.sv
// types shared by the target and host ends of the nand link
package ntim_pkg;
  typedef enum logic {DS_PWRUP, DS_RUN} ntim_dev_state_t;
  typedef enum logic [1:0] {OM_NONE, OM_STATUS, OM_DATA} ntim_out_mode_t;
  typedef enum logic [2:0] {
    HS_PWR, HS_IDLE, HS_CMD, HS_ADDR, HS_RBWAIT, HS_BURST, HS_POST
  } ntim_host_state_t;
  typedef enum logic [2:0] {
    OP_STATUS, OP_UNIT_STATUS, OP_READ, OP_FULL_REINIT, OP_INIT
  } ntim_op_t;
endpackage

// ### src/ntim_link_if.sv
// nand target bus between host and target, with optional mirrored board wiring
`timescale 1ns/1ps
`default_nettype none
interface ntim_link_if #(parameter bit MIRROR_WIRING = 1'b0);
  logic       ce_n;
  logic       cle;
  logic       ale;
  logic       we_n;
  logic       read_enable_n;
  logic [7:0] h_dq_o;
  logic       h_dq_oe;
  logic [7:0] h_dq_i;
  logic [7:0] d_dq_o;
  logic       d_dq_oe;
  logic [7:0] d_dq_i;
  logic       dqs;
  logic       rb_n;
  logic [7:0] h_wire;
  logic [7:0] d_wire;
  logic [7:0] d_rev;

  // a clamshell board crosses the eight data lines, nothing else
  for (genvar i = 0; i < 8; i++) begin : g_wire
    assign d_wire[i] = MIRROR_WIRING ? h_wire[7-i] : h_wire[i];
  end
  assign h_wire = h_dq_oe ? h_dq_o : (d_dq_oe ? d_rev : 8'h00);
  assign h_dq_i = h_wire;
  assign d_dq_i = h_dq_oe ? d_wire : d_dq_o;

  for (genvar j = 0; j < 8; j++) begin : g_back
    assign d_rev[j] = MIRROR_WIRING ? d_dq_o[7-j] : d_dq_o[j];
  end

  modport host (output ce_n, cle, ale, we_n, read_enable_n, h_dq_o, h_dq_oe,
                input  h_dq_i, dqs, rb_n);
  modport dev  (input  ce_n, cle, ale, we_n, read_enable_n, d_dq_i,
                output d_dq_o, d_dq_oe, dqs, rb_n);
endinterface
`default_nettype wire

// ### src/ntim_host.sv
// nand host end: power-on sequence, command, address and ddr read cycles
`timescale 1ns/1ps
`default_nettype none
`include "ntim_defines.svh"

module ntim_host (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               en_i,
  input  wire logic               watch_rb_i,
  input  wire logic               op_valid_i,
  input  wire ntim_pkg::ntim_op_t op_i,
  input  wire logic               unit_i,
  input  wire logic [7:0]         nbytes_i,
  ntim_link_if.host               link,
  output logic                    ready_o,
  output logic                    init_done_o,
  output logic [7:0]              rdata_o,
  output logic                    rdata_valid_o,
  output logic [7:0]              status_o
);
  import ntim_pkg::*;

  localparam logic [15:0] HALF = 16'(`NTIM_HALF_CYC);

  logic [9:0]       s1_q, s2_q;
  logic             dqs_d_q;
  ntim_host_state_t st_q;
  ntim_op_t         op_q;
  logic [15:0]      cnt_q;
  logic [7:0]       byte_q, nb_q, edges_q;
  logic             ce_n_q, cle_q, ale_q, we_n_q, re_n_q, dq_oe_q, drive_q;
  logic             ready_q, init_q, rv_q;
  logic [7:0]       rdata_q, status_q;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // strobe bit starts at its idle high level
      s1_q    <= 10'h100;
      s2_q    <= 10'h100;
      dqs_d_q <= 1'b1;
    end else if (en_i) begin
      s1_q    <= {link.rb_n, link.dqs, link.h_dq_i};
      s2_q    <= s1_q;
      dqs_d_q <= s2_q[8];
    end
  end

  wire rb_s  = s2_q[9];
  wire dqs_s = s2_q[8];
  wire in_rd = (st_q == HS_BURST) || (st_q == HS_POST);
  wire last  = (cnt_q == 2 * HALF - 16'h0001);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // every bus cycle is a full strobe period; the op decides the next step
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q    <= HS_PWR;
      op_q    <= OP_INIT;
      cnt_q   <= 16'h0000;
      byte_q  <= 8'h00;
      nb_q    <= 8'h02;
      edges_q <= 8'h00;
      ce_n_q  <= 1'b1;
      cle_q   <= 1'b0;
      ale_q   <= 1'b0;
      we_n_q  <= 1'b1;
      re_n_q  <= 1'b1;
      dq_oe_q <= 1'b0;
      ready_q <= 1'b0;
      init_q  <= 1'b0;
    end else if (en_i) begin
      cnt_q <= cnt_q + 16'h0001;
      case (st_q)
        HS_PWR: begin
          // wait for valid ready, or the fixed delay when not watching it
          if (watch_rb_i ? rb_s : (cnt_q >= 16'(`NTIM_HOST_WAIT_CYC))) begin
            st_q   <= HS_CMD;
            byte_q <= `NTIM_CMD_RESET;
            ce_n_q <= 1'b0;
            cle_q  <= 1'b1;
            dq_oe_q <= 1'b1;
            cnt_q  <= 16'h0000;
          end
        end
        HS_IDLE: begin
          // page crc, copy search and block map run in software above op_i
          if (op_valid_i && op_i != OP_INIT) begin
            op_q    <= op_i;
            nb_q    <= (nbytes_i[7:1] == 7'h00) ? 8'h02 : {nbytes_i[7:1], 1'b0};
            ready_q <= 1'b0;
            st_q    <= HS_CMD;
            cle_q   <= 1'b1;
            dq_oe_q <= 1'b1;
            cnt_q   <= 16'h0000;
            case (op_i)
              OP_STATUS:      byte_q <= `NTIM_CMD_STATUS;
              OP_UNIT_STATUS: byte_q <= `NTIM_CMD_UNIT_STATUS;
              OP_READ:        byte_q <= `NTIM_CMD_READ_SETUP;
              default:        byte_q <= `NTIM_CMD_FULL_REINIT;
            endcase
          end
        end
        HS_CMD, HS_ADDR: begin
          if (cnt_q == 16'h0000) we_n_q <= 1'b0;
          if (cnt_q == HALF) we_n_q <= 1'b1;
          if (last) begin
            cle_q   <= 1'b0;
            ale_q   <= 1'b0;
            dq_oe_q <= 1'b0;
            cnt_q   <= 16'h0000;
            edges_q <= 8'h00;
            if (st_q == HS_CMD && (byte_q == `NTIM_CMD_UNIT_STATUS ||
                                   byte_q == `NTIM_CMD_READ_SETUP)) begin
              st_q    <= HS_ADDR;
              ale_q   <= 1'b1;
              dq_oe_q <= 1'b1;
              byte_q  <= (op_q == OP_UNIT_STATUS) ? {7'h00, unit_i} : 8'h00;
            end else if (st_q == HS_ADDR && op_q == OP_READ) begin
              st_q    <= HS_CMD;
              cle_q   <= 1'b1;
              dq_oe_q <= 1'b1;
              byte_q  <= `NTIM_CMD_READ_GO;
            end else if (byte_q == `NTIM_CMD_STATUS || op_q == OP_UNIT_STATUS) begin
              st_q <= HS_BURST;
            end else begin
              st_q <= HS_RBWAIT;
            end
          end
        end
        HS_RBWAIT: begin
          // track completion by ready/busy; no new reset meanwhile
          if (cnt_q >= 16'(`NTIM_RB_GUARD_CYC) && rb_s) begin
            cnt_q <= 16'h0000;
            if (op_q == OP_READ) begin
              st_q <= HS_BURST;
            end else if (op_q == OP_INIT) begin
              st_q    <= HS_CMD;
              cle_q   <= 1'b1;
              dq_oe_q <= 1'b1;
              byte_q  <= `NTIM_CMD_STATUS;
            end else begin
              st_q    <= HS_IDLE;
              ready_q <= 1'b1;
            end
          end
        end
        HS_BURST: begin
          if (cnt_q == HALF - 16'h0001) begin
            re_n_q  <= ~re_n_q;
            edges_q <= edges_q + 8'h01;
            cnt_q   <= 16'h0000;
            if (edges_q + 8'h01 == nb_q) st_q <= HS_POST;
          end
        end
        HS_POST: begin
          // read enable held steady through the postamble and capture latency
          if (cnt_q == 16'(`NTIM_RPST_CYC + `NTIM_CAPTURE_LAT_CYC)) begin
            cnt_q <= 16'h0000;
            if (op_q == OP_INIT && !status_q[`NTIM_ST_RDY_BIT]) begin
              st_q    <= HS_CMD;   // poll again with plain status
              cle_q   <= 1'b1;
              dq_oe_q <= 1'b1;
            end else begin
              st_q    <= HS_IDLE;
              ready_q <= 1'b1;
              init_q  <= 1'b1;
            end
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // data line drive
  // ---------------------------------------------------------------
  // dq driven only from the fifth clock of a bus cycle: the target sees
  // cle or ale three clocks late and must have let go of the lines first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_q <= 1'b0;
    end else if (en_i) begin
      drive_q <= dq_oe_q && (cnt_q >= 16'h0003);
    end
  end

  // ---------------------------------------------------------------
  // read capture
  // ---------------------------------------------------------------
  // each strobe edge during a burst carries one byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rv_q     <= 1'b0;
      rdata_q  <= 8'h00;
      status_q <= 8'h00;
    end else if (en_i) begin
      rv_q <= in_rd && (dqs_s != dqs_d_q);
      if (in_rd && dqs_s != dqs_d_q) begin
        rdata_q <= s2_q[7:0];
        if (op_q != OP_READ) status_q <= s2_q[7:0];
      end
    end
  end

  assign link.ce_n          = ce_n_q;
  assign link.cle           = cle_q;
  assign link.ale           = ale_q;
  assign link.we_n          = we_n_q;
  assign link.read_enable_n = re_n_q;
  assign link.h_dq_o        = byte_q;
  assign link.h_dq_oe       = drive_q;
  assign ready_o            = ready_q;
  assign init_done_o        = init_q;
  assign rdata_o            = rdata_q;
  assign rdata_valid_o      = rv_q;
  assign status_o           = status_q;
endmodule // ntim_host
`default_nettype wire

// ### test/ntim_link_properties.sv
// checker for the nand link: strobe timing, ready/busy and bus ownership
`timescale 1ns/1ps
`default_nettype none
module ntim_link_properties #(
  parameter int unsigned POR_CYC = 300
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cle,
  input wire logic       we_n,
  input wire logic       read_enable_n,
  input wire logic [7:0] h_dq_o,
  input wire logic       h_dq_oe,
  input wire logic       d_dq_oe,
  input wire logic       dqs,
  input wire logic       rb_n
);
  logic        st_q;
  logic [15:0] lo_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------
  // helpers
  // ----------------
  // last command was a status read, which a busy target must still answer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_q <= 1'b0;
    else if (cle && $rose(we_n)) st_q <= (h_dq_o == 8'h70) || (h_dq_o == 8'h78);
  end
  // length of the current busy period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lo_q <= 16'h0000;
    else lo_q <= rb_n ? 16'h0000 : lo_q + 16'h0001;
  end
  // ----------------
  // assertions
  // ----------------
  dqs_fall_a: assert property (
    $fell(read_enable_n) && (rb_n || st_q) |-> ##[2:6] $fell(dqs)) else $error("no strobe fall");
  dqs_rise_a: assert property (
    $rose(read_enable_n) && (rb_n || st_q) |-> ##[2:6] $rose(dqs)) else $error("no strobe rise");
  dqs_hold_a: assert property ($fell(dqs) |-> !dqs [*3])
    else $error("strobe low too short");
  bus_fight_a: assert property (!(h_dq_oe && d_dq_oe))
    else $error("both ends drive dq");
  busy_quiet_a: assert property (!rb_n && !st_q |-> !d_dq_oe)
    else $error("busy target drove data");
  reset_busy_a: assert property ($rose(rst_n_i) |-> !rb_n [*8])
    else $error("ready too soon after reset");
  busy_max_a: assert property (int'(lo_q) < POR_CYC + 8)
    else $error("busy period too long");
  busy_min_a: assert property ($rose(rb_n) |-> $past(lo_q) >= 16'h002d)
    else $error("busy period too short");
endmodule // ntim_link_properties
`default_nettype wire

// ### test/nand_target_init_and_dq_mirroring_tb.sv
// bench: straight and mirrored host/target pairs run the same operations
`timescale 1ns/1ps
`default_nettype none
module nand_target_init_and_dq_mirroring_tb;
  import ntim_pkg::*;
  localparam int unsigned POR = 300;
  logic            clk_i;
  logic            rst_n_i;
  logic            op_valid;
  ntim_op_t        op;
  logic            unit;
  logic [7:0]      nbytes;
  wire  [1:0]      rdy, done, rv, mir, asy, seqi, pari, lun, bsy;
  wire  [1:0][7:0] rdat, stat;
  logic [7:0]      q [2][$];
  int              mismatches = 0;
  int              comparisons = 0;
  int              cyc = 0;
  int              seed;
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ----------------
  // pairs: 0 straight with host watching ready/busy, 1 mirrored board, timed wait
  // ----------------
  for (genvar g = 0; g < 2; g++) begin : g_pair
    ntim_link_if #(.MIRROR_WIRING(g == 1)) ntim_link_if_i ();
    ntim_host ntim_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1), .watch_rb_i(g == 0),
      .op_valid_i(op_valid), .op_i(op), .unit_i(unit), .nbytes_i(nbytes),
      .link(ntim_link_if_i.host), .ready_o(rdy[g]), .init_done_o(done[g]),
      .rdata_o(rdat[g]), .rdata_valid_o(rv[g]), .status_o(stat[g]));
    ntim_target #(.POR_CYC(POR)) ntim_target_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .en_i(1'b1), .vccq_1v8_i(1'b1), .cs_reduce_i(1'b1), .link(ntim_link_if_i.dev),
      .mirrored_o(mir[g]), .async_if_o(asy[g]), .seq_init_o(seqi[g]), .par_init_o(pari[g]),
      .lun_sel_o(lun[g]), .busy_o(bsy[g]));
    if (g == 0) begin : g_chk
      ntim_link_properties #(.POR_CYC(POR)) ntim_link_properties_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .cle(ntim_link_if_i.cle), .we_n(ntim_link_if_i.we_n),
        .read_enable_n(ntim_link_if_i.read_enable_n), .h_dq_o(ntim_link_if_i.h_dq_o),
        .h_dq_oe(ntim_link_if_i.h_dq_oe), .d_dq_oe(ntim_link_if_i.d_dq_oe),
        .dqs(ntim_link_if_i.dqs), .rb_n(ntim_link_if_i.rb_n));
    end
  end
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // both hosts idle; a timed-wait host takes far longer through power-on
  task automatic wait_ready();
    int k;
    k = 0;
    while (!(rdy === 2'b11 && done === 2'b11) && k < 4000) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 4000) mismatches++;
  endtask
  // notes the expected bytes, then offers one operation to both hosts
  task automatic do_op(input ntim_op_t o, input logic u, input logic [7:0] n);
    wait_ready();
    for (int g = 0; g < 2; g++)
      for (int b = 0; b < ((o == OP_READ) ? n : (o == OP_FULL_REINIT) ? 0 : 2); b++)
        q[g].push_back((o == OP_READ) ? 8'(b) : 8'he0);
    op = o;
    unit = u;
    nbytes = n;
    op_valid = 1'b1;
    @(negedge clk_i);
    op_valid = 1'b0;
    @(negedge clk_i);
    wait_ready();
  endtask
  // each byte handed up once init is done is matched with the oldest note
  always @(negedge clk_i) begin
    for (int g = 0; g < 2; g++)
      if (rv[g] === 1'b1 && done[g] === 1'b1)
        chk(rdat[g], (q[g].size() != 0) ? q[g].pop_front() : 8'hxx);
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------------
  // sequence
  // ----------------
  initial begin
    seed = 32'hdce5;
    rst_n_i = 1'b0;
    op_valid = 1'b0;
    op = OP_STATUS;
    unit = 1'b0;
    nbytes = 8'h02;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    wait_ready();
    for (int g = 0; g < 2; g++) begin
      chk({7'h0, asy[g]}, 8'h01);
      chk({7'h0, lun[g]}, 8'h00);
      chk({7'h0, mir[g]}, 8'(g));
      chk({6'h0, seqi[g], pari[g]}, 8'h01);
    end
    chk({6'h00, bsy}, 8'h00);
    do_op(OP_STATUS, 1'b0, 8'h02);
    for (int g = 0; g < 2; g++) chk(stat[g], 8'he0);
    do_op(OP_UNIT_STATUS, 1'b1, 8'h02);
    for (int g = 0; g < 2; g++) chk({7'h0, lun[g]}, 8'h01);
    repeat (3) do_op(OP_READ, 1'b0, 8'(($random(seed) & 14) + 2));
    do_op(OP_FULL_REINIT, 1'b0, 8'h02);
    for (int g = 0; g < 2; g++) chk({7'h0, mir[g]}, 8'(g));
    do_op(OP_READ, 1'b0, 8'h10);
    for (int g = 0; g < 2; g++) chk(8'(q[g].size()), 8'h00);
    final_report();
  end
endmodule // nand_target_init_and_dq_mirroring_tb
`default_nettype wire
